// ---- common/fault_rec_pkg.sv ----
// How it works
// - Parallel record holds at most two faults; the late one is a multiply overflow.
// - Fault call syncs; a pending late fault yields one combined record.
// - Parallel handler entry clears trace enable; return restores the old value.
// - Parallel handler is always entered through a supervisor call.
// - Fault n entry sits at new frame pointer minus 8 minus n times 32.
// - Primary fault fills first 32 bytes; others go to the optional section.
// - Override word: type 00H at new_frame_pointer-18, count at new_frame_pointer-20.
// - Extra faults get 32-byte entries from new_frame_pointer-65: type, subtype, ip, data.
// - Non-parallel handler mode follows entry type; handler addresses are word aligned.
// - Handler return resumes the pending program at the resume pointer.
// - Faults raised before execution resume at the faulting instruction.
// - Integer overflow still writes the overflowed result to the destination.
// - Operation, constraint, trace, zero-divide, length faults resumable; overflow not.
// - Resume pointer is saved in the faulting frame at previous frame pointer plus 8.
// - Resume pointer names faulting or next instruction, or is flagged undefined.
// - Parallel return continues at the next instruction not yet executed.
// - Faults combine only while the no-imprecise flag is zero.
// - Any undefined resume pointer makes the parallel resume pointer undefined.
// - Frame pointer rounds up to 16 bytes, then 80 record bytes are reserved.
package fault_rec_pkg;

  localparam int unsigned AW = 32;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned REC_WORDS = 25;
  localparam int unsigned MAX_FAULTS = 2;
  localparam int unsigned SYNC_CYCLES = 4;

  // ----------------------------------------------------------------
  // Frame and record geometry (bytes)
  // ----------------------------------------------------------------
  localparam logic [31:0] FRAME_ALIGN_M1 = 32'h0000_000F;
  localparam logic [31:0] REC_ALLOC = 32'h0000_0050;
  localparam logic [31:0] REC_BELOW = 32'h0000_0060;
  localparam logic [31:0] RSM_PFP_OFS = 32'h0000_0008;
  localparam int unsigned ENTRY_HDR = 8;
  localparam int unsigned ENTRY_BYTES = 32;
  localparam int unsigned SEC_N = 2;

  // ----------------------------------------------------------------
  // Word indices, word 0 sits at new_frame_pointer-96, word 24 is the saved pointer
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_OVR = 5'h13;
  localparam logic [4:0] IDX_DATA = 5'h12;
  localparam logic [4:0] IDX_PC = 5'h14;
  localparam logic [4:0] IDX_AC = 5'h15;
  localparam logic [4:0] IDX_TYPE = 5'h16;
  localparam logic [4:0] IDX_IP = 5'h17;
  localparam logic [4:0] IDX_RSM = 5'h18;
  localparam logic [4:0] IDX_LAST = 5'h18;
  localparam logic [4:0] SEC_TYPE_IDX =
    5'((32'(REC_BELOW) - ENTRY_HDR - SEC_N * ENTRY_BYTES) / 4);
  localparam logic [4:0] SEC_IP_IDX = 5'(SEC_TYPE_IDX + 5'h01);
  localparam logic [4:0] SEC_DATA_IDX =
    5'((32'(REC_BELOW) - (SEC_N + 1) * ENTRY_BYTES) / 4);

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int unsigned TYPE_LSB = 16;
  localparam int unsigned SUB_LSB = 0;
  localparam int unsigned OVERRIDE_TYPE_FIELD_LSB = 16;
  localparam int unsigned OCOUNT_LSB = 0;
  localparam logic [7:0] FT_PARALLEL = 8'h00;
  localparam logic [7:0] FT_NONE = 8'hFF;
  localparam logic [7:0] FT_TRACE = 8'h01;
  localparam logic [7:0] FT_OPERATION = 8'h02;
  localparam logic [7:0] FT_ARITH = 8'h03;
  localparam logic [7:0] FT_CONSTRAINT = 8'h05;
  localparam logic [7:0] FT_PROTECTION = 8'h07;
  localparam logic [7:0] ST_INT_OVF = 8'h01;
  localparam logic [7:0] ST_ZERO_DIV = 8'h02;
  localparam logic [7:0] ST_LENGTH = 8'h02;
  localparam logic [31:0] WORD_ALIGN_MASK = 32'hFFFF_FFFC;

  typedef struct packed {
    logic [7:0] ftype;
    logic [7:0] fsub;
    logic [31:0] ip;
    logic [31:0] data;
    logic [31:0] rsm;
    logic rsm_def;
    logic [31:0] result;
    logic [4:0] dest;
  } fault_info_t;

  typedef struct packed {
    logic [31:0] ip;
    logic sup_mode;
  } handler_entry_t;

  typedef struct packed {
    logic [31:0] ip;
    logic [31:0] frame;
    logic sup_mode;
    logic parallel;
  } call_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SYNC = 3'h1,
    ST_BUILD = 3'h3,
    ST_RD = 3'h2,
    ST_WR = 3'h6,
    ST_CALL = 3'h7,
    ST_HAND = 3'h5
  } state_t;

endpackage : fault_rec_pkg

// ---- hdl/record_store.sv ----
`timescale 1ns/1ns
module record_store #(
  parameter int unsigned W = 32,
  parameter int unsigned DEPTH = 25,
  parameter int unsigned IW = 5
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [IW-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [IW-1:0] rd_idx,
  output logic [W-1:0] rd_data_q
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Registered read keeps the memory write port glitch free
  always_ff @(posedge clk_sys) begin
    rd_data_q <= mem[rd_idx];
  end

endmodule : record_store

// ---- hdl/parallel_fault_recorder.sv ----
`timescale 1ns/1ns
module parallel_fault_recorder #(
  parameter int unsigned SYNC_CYCLES = fault_rec_pkg::SYNC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fault_req,
  input fault_rec_pkg::fault_info_t fault_info,
  input wire logic late_ovf_valid,
  input fault_rec_pkg::fault_info_t late_ovf_info,
  input wire logic no_imprecise_flag,
  input wire logic pc_trace_enable,
  input wire logic [31:0] pc_word,
  input wire logic [31:0] ac_word,
  input wire logic [31:0] stack_ptr,
  input wire logic [31:0] prev_fp,
  input wire logic [31:0] next_ip,
  input fault_rec_pkg::handler_entry_t fault_entry,
  input fault_rec_pkg::handler_entry_t parallel_entry,
  input wire logic mem_wr_ready,
  input wire logic handler_ret,
  output logic busy,
  output logic mem_wr_valid,
  output logic [31:0] mem_wr_addr,
  output logic [31:0] mem_wr_data,
  output logic rf_wr_en,
  output logic [4:0] rf_wr_idx,
  output logic [31:0] rf_wr_data,
  output logic call_valid,
  output fault_rec_pkg::call_t call,
  output logic trace_enable_bit,
  output logic resume_valid,
  output logic [31:0] resume_pointer,
  output logic resume_defined,
  output logic resumable
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_resumable(input logic [7:0] t, input logic [7:0] s);
    logic r;
    r = 1'b0;
    if (t == fault_rec_pkg::FT_OPERATION || t == fault_rec_pkg::FT_CONSTRAINT ||
        t == fault_rec_pkg::FT_TRACE) begin
      r = 1'b1;
    end
    if (t == fault_rec_pkg::FT_ARITH && s == fault_rec_pkg::ST_ZERO_DIV) begin
      r = 1'b1;
    end
    if (t == fault_rec_pkg::FT_PROTECTION && s == fault_rec_pkg::ST_LENGTH) begin
      r = 1'b1;
    end
    return r;
  endfunction : is_resumable

  function automatic logic is_int_ovf(input fault_rec_pkg::fault_info_t f);
    return f.ftype == fault_rec_pkg::FT_ARITH && f.fsub == fault_rec_pkg::ST_INT_OVF;
  endfunction : is_int_ovf

  function automatic logic [31:0] type_word(input fault_rec_pkg::fault_info_t f);
    logic [31:0] w;
    w = '0;
    w[fault_rec_pkg::TYPE_LSB +: 8] = f.ftype;
    w[fault_rec_pkg::SUB_LSB +: 8] = f.fsub;
    return w;
  endfunction : type_word

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fault_rec_pkg::state_t state_q;
  fault_rec_pkg::fault_info_t prim_q;
  fault_rec_pkg::fault_info_t sec_q;
  fault_rec_pkg::fault_info_t pend_info_q;
  logic pend_q;
  logic take_pend;
  logic par_q;
  logic [7:0] sync_cnt_q;
  logic [4:0] widx_q;
  logic [4:0] ridx_q;
  logic [31:0] frame_q;
  logic [31:0] pfp_q;
  logic [31:0] pc_q;
  logic [31:0] ac_q;
  logic [31:0] rsm_q;
  logic rsm_def_q;
  logic res_q;
  logic trace_saved_q;
  logic [31:0] wdata;
  logic [31:0] fp_round;
  logic sync_done;
  logic rf_pend_q;
  logic [4:0] rf_pend_idx_q;
  logic [31:0] rf_pend_data_q;

  assign sync_done = (sync_cnt_q == 8'(SYNC_CYCLES - 1));
  assign take_pend = (state_q == fault_rec_pkg::ST_IDLE && !fault_req && pend_q) ||
                     (state_q == fault_rec_pkg::ST_SYNC && sync_done && pend_q &&
                      !no_imprecise_flag);
  assign fp_round = (stack_ptr + fault_rec_pkg::FRAME_ALIGN_M1) &
                    ~fault_rec_pkg::FRAME_ALIGN_M1;

  // ----------------------------------------------------------------
  // Late multiply overflow holding register
  // ----------------------------------------------------------------
  // Only the multiply overflow can arrive late, so it is the only second entry
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      pend_info_q <= '0;
    end else if (late_ovf_valid) begin
      pend_q <= 1'b1;
      pend_info_q <= late_ovf_info;
    end else if (take_pend) begin
      pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= fault_rec_pkg::ST_IDLE;
      prim_q <= '0;
      sec_q <= '0;
      par_q <= 1'b0;
      sync_cnt_q <= '0;
      widx_q <= '0;
      ridx_q <= '0;
      frame_q <= '0;
      pfp_q <= '0;
      pc_q <= '0;
      ac_q <= '0;
    end else begin
      case (state_q)
        fault_rec_pkg::ST_IDLE: begin
          if (fault_req || pend_q) begin
            prim_q <= fault_req ? fault_info : pend_info_q;
            par_q <= 1'b0;
            sync_cnt_q <= '0;
            frame_q <= fp_round + fault_rec_pkg::REC_ALLOC;
            pfp_q <= prev_fp;
            pc_q <= pc_word;
            ac_q <= ac_word;
            state_q <= fault_rec_pkg::ST_SYNC;
          end
        end
        fault_rec_pkg::ST_SYNC: begin
          sync_cnt_q <= sync_cnt_q + 8'h01;
          if (sync_done) begin
            // A late fault held back by the no-imprecise flag stays pending
            if (pend_q && !no_imprecise_flag) begin
              sec_q <= pend_info_q;
              par_q <= 1'b1;
            end
            widx_q <= '0;
            state_q <= fault_rec_pkg::ST_BUILD;
          end
        end
        fault_rec_pkg::ST_BUILD: begin
          widx_q <= widx_q + 5'h01;
          if (widx_q == fault_rec_pkg::IDX_LAST) begin
            ridx_q <= '0;
            state_q <= fault_rec_pkg::ST_RD;
          end
        end
        fault_rec_pkg::ST_RD: begin
          state_q <= fault_rec_pkg::ST_WR;
        end
        fault_rec_pkg::ST_WR: begin
          if (mem_wr_ready) begin
            ridx_q <= ridx_q + 5'h01;
            state_q <= (ridx_q == fault_rec_pkg::IDX_LAST) ?
                       fault_rec_pkg::ST_CALL : fault_rec_pkg::ST_RD;
          end
        end
        fault_rec_pkg::ST_CALL: begin
          state_q <= fault_rec_pkg::ST_HAND;
        end
        fault_rec_pkg::ST_HAND: begin
          if (handler_ret) begin
            state_q <= fault_rec_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= fault_rec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Resume pointer and resumability
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsm_q <= '0;
      rsm_def_q <= 1'b0;
      res_q <= 1'b0;
    end else if (state_q == fault_rec_pkg::ST_SYNC && sync_done) begin
      if (pend_q && !no_imprecise_flag) begin
        rsm_q <= next_ip;
        rsm_def_q <= prim_q.rsm_def && pend_info_q.rsm_def;
        res_q <= is_resumable(prim_q.ftype, prim_q.fsub) &&
                 is_resumable(pend_info_q.ftype, pend_info_q.fsub);
      end else begin
        // Faults taken before execution point back at the instruction itself
        rsm_q <= (prim_q.ftype == fault_rec_pkg::FT_OPERATION) ?
                 prim_q.ip : prim_q.rsm;
        rsm_def_q <= prim_q.rsm_def;
        res_q <= is_resumable(prim_q.ftype, prim_q.fsub);
      end
    end
  end

  // ----------------------------------------------------------------
  // Record image
  // ----------------------------------------------------------------
  always_comb begin
    wdata = '0;
    case (widx_q)
      fault_rec_pkg::IDX_OVR: begin
        wdata[fault_rec_pkg::OVERRIDE_TYPE_FIELD_LSB +: 8] = par_q ?
          fault_rec_pkg::FT_PARALLEL : fault_rec_pkg::FT_NONE;
        wdata[fault_rec_pkg::OCOUNT_LSB +: 8] = par_q ?
          8'(fault_rec_pkg::MAX_FAULTS) : 8'h01;
      end
      fault_rec_pkg::IDX_PC: wdata = pc_q;
      fault_rec_pkg::IDX_AC: wdata = ac_q;
      fault_rec_pkg::IDX_TYPE: wdata = type_word(prim_q);
      fault_rec_pkg::IDX_IP: wdata = prim_q.ip;
      fault_rec_pkg::IDX_DATA: wdata = prim_q.data;
      fault_rec_pkg::IDX_RSM: wdata = rsm_q;
      fault_rec_pkg::SEC_TYPE_IDX: wdata = par_q ? type_word(sec_q) : '0;
      fault_rec_pkg::SEC_IP_IDX: wdata = par_q ? sec_q.ip : '0;
      fault_rec_pkg::SEC_DATA_IDX: wdata = par_q ? sec_q.data : '0;
      default: wdata = '0;
    endcase
  end

  record_store #(
    .W(32),
    .DEPTH(fault_rec_pkg::REC_WORDS),
    .IW(fault_rec_pkg::IDX_W)
  ) u_store (
    .clk_sys(clk_sys),
    .wr_en(state_q == fault_rec_pkg::ST_BUILD),
    .wr_idx(widx_q),
    .wr_data(wdata),
    .rd_idx(ridx_q),
    .rd_data_q(mem_wr_data)
  );

  // ----------------------------------------------------------------
  // Memory write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= '0;
    end else if (state_q == fault_rec_pkg::ST_RD) begin
      mem_wr_valid <= 1'b1;
      if (ridx_q == fault_rec_pkg::IDX_RSM) begin
        mem_wr_addr <= pfp_q + fault_rec_pkg::RSM_PFP_OFS;
      end else begin
        mem_wr_addr <= frame_q - fault_rec_pkg::REC_BELOW +
                       32'({ridx_q, 2'b00});
      end
    end else if (state_q == fault_rec_pkg::ST_WR && mem_wr_ready) begin
      mem_wr_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Handler call, trace enable and resume
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      call_valid <= 1'b0;
      call <= '0;
      resumable <= 1'b0;
    end else begin
      call_valid <= (state_q == fault_rec_pkg::ST_CALL);
      if (state_q == fault_rec_pkg::ST_CALL) begin
        call.frame <= frame_q;
        call.parallel <= par_q;
        resumable <= res_q;
        if (par_q) begin
          call.ip <= parallel_entry.ip & fault_rec_pkg::WORD_ALIGN_MASK;
          call.sup_mode <= 1'b1;
        end else begin
          call.ip <= fault_entry.ip & fault_rec_pkg::WORD_ALIGN_MASK;
          call.sup_mode <= fault_entry.sup_mode;
        end
      end
    end
  end

  // The parallel handler must not re-enable tracing, or it would trap itself
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trace_enable_bit <= 1'b0;
      trace_saved_q <= 1'b0;
    end else if (state_q == fault_rec_pkg::ST_IDLE) begin
      trace_enable_bit <= pc_trace_enable;
    end else if (state_q == fault_rec_pkg::ST_CALL && par_q) begin
      trace_saved_q <= trace_enable_bit;
      trace_enable_bit <= 1'b0;
    end else if (state_q == fault_rec_pkg::ST_HAND && handler_ret && par_q) begin
      trace_enable_bit <= trace_saved_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resume_valid <= 1'b0;
      resume_pointer <= '0;
      resume_defined <= 1'b0;
      busy <= 1'b0;
    end else begin
      busy <= (state_q != fault_rec_pkg::ST_IDLE) || fault_req || pend_q;
      resume_valid <= (state_q == fault_rec_pkg::ST_HAND) && handler_ret;
      if (state_q == fault_rec_pkg::ST_CALL) begin
        resume_pointer <= rsm_q;
        resume_defined <= rsm_def_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Destination write of an overflowed result
  // ----------------------------------------------------------------
  // A late overflow and a fresh overflow can meet; the fresh one waits a cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rf_wr_en <= 1'b0;
      rf_wr_idx <= '0;
      rf_wr_data <= '0;
      rf_pend_q <= 1'b0;
      rf_pend_idx_q <= '0;
      rf_pend_data_q <= '0;
    end else begin
      rf_wr_en <= 1'b0;
      if (late_ovf_valid) begin
        rf_wr_en <= 1'b1;
        rf_wr_idx <= late_ovf_info.dest;
        rf_wr_data <= late_ovf_info.result;
        if (fault_req && is_int_ovf(fault_info)) begin
          rf_pend_q <= 1'b1;
          rf_pend_idx_q <= fault_info.dest;
          rf_pend_data_q <= fault_info.result;
        end
      end else if (rf_pend_q) begin
        rf_wr_en <= 1'b1;
        rf_wr_idx <= rf_pend_idx_q;
        rf_wr_data <= rf_pend_data_q;
        rf_pend_q <= 1'b0;
      end else if (fault_req && is_int_ovf(fault_info)) begin
        rf_wr_en <= 1'b1;
        rf_wr_idx <= fault_info.dest;
        rf_wr_data <= fault_info.result;
      end
    end
  end

endmodule : parallel_fault_recorder

// ---- bench/parallel_fault_recorder_assertions.sv ----
`timescale 1ns/1ns
module parallel_fault_recorder_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fault_req,
  input fault_rec_pkg::fault_info_t fault_info,
  input wire logic late_ovf_valid,
  input fault_rec_pkg::fault_info_t late_ovf_info,
  input wire logic handler_ret,
  input wire logic mem_wr_ready,
  input wire logic busy,
  input wire logic mem_wr_valid,
  input wire logic [31:0] mem_wr_addr,
  input wire logic [31:0] mem_wr_data,
  input wire logic rf_wr_en,
  input wire logic [4:0] rf_wr_idx,
  input wire logic [31:0] rf_wr_data,
  input wire logic call_valid,
  input fault_rec_pkg::call_t call,
  input wire logic trace_enable_bit,
  input wire logic resume_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Handler tracking
  // ------------------------------------------------------------
  logic par_q;
  logic hand_q;
  logic te_sv_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      par_q <= 1'b0;
      hand_q <= 1'b0;
      te_sv_q <= 1'b0;
    end else if (call_valid) begin
      par_q <= call.parallel;
      hand_q <= 1'b1;
      te_sv_q <= $past(trace_enable_bit);
    end else if (resume_valid) begin
      hand_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  late_write_a: assert property (late_ovf_valid |=> rf_wr_en &&
    rf_wr_idx == $past(late_ovf_info.dest) && rf_wr_data == $past(late_ovf_info.result))
    else $error("late overflow result not written");
  ovf_write_a: assert property (fault_req && !busy && !late_ovf_valid &&
    fault_info.ftype == fault_rec_pkg::FT_ARITH && fault_info.fsub == fault_rec_pkg::ST_INT_OVF
    |=> rf_wr_en && rf_wr_data == $past(fault_info.result))
    else $error("overflow result not written");
  trace_clear_a: assert property (call_valid && call.parallel |-> !trace_enable_bit)
    else $error("trace left on in parallel handler");
  trace_restore_a: assert property (resume_valid && par_q |-> trace_enable_bit == te_sv_q)
    else $error("trace not restored");
  par_super_a: assert property (call_valid && call.parallel |-> call.sup_mode)
    else $error("parallel handler not supervisor");
  entry_align_a: assert property (call_valid |-> call.ip[1:0] == 2'h0)
    else $error("handler address not word aligned");
  frame_align_a: assert property (call_valid |-> call.frame[3:0] == 4'h0)
    else $error("frame pointer not aligned");
  ret_resume_a: assert property (hand_q && handler_ret |=> resume_valid)
    else $error("no resume after return");
  call_time_a: assert property (fault_req && !busy |-> ##[30:1000] call_valid)
    else $error("handler call missing");
  wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("record write dropped");

  cover property (call_valid && call.parallel);
  cover property (call_valid && !call.parallel);
  cover property (hand_q && handler_ret);
endmodule : parallel_fault_recorder_assertions

bind parallel_fault_recorder parallel_fault_recorder_assertions chk (.clk_sys, .rst,
  .fault_req, .fault_info, .late_ovf_valid, .late_ovf_info, .handler_ret, .mem_wr_ready,
  .busy, .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .rf_wr_en, .rf_wr_idx, .rf_wr_data,
  .call_valid, .call, .trace_enable_bit, .resume_valid);

// ---- bench/parallel_fault_recorder_tb.sv ----
`timescale 1ns/1ns
module parallel_fault_recorder_tb;
  logic clk_sys, rst, fault_req, late_ovf_valid, no_imprecise_flag, pc_trace_enable;
  logic mem_wr_ready, handler_ret, busy, mem_wr_valid, rf_wr_en, call_valid;
  logic trace_enable_bit, resume_valid, resume_defined, resumable;
  logic [31:0] pc_word, ac_word, stack_ptr, prev_fp, next_ip;
  logic [31:0] mem_wr_addr, mem_wr_data, rf_wr_data, resume_pointer;
  logic [4:0] rf_wr_idx;
  fault_rec_pkg::fault_info_t fault_info, late_ovf_info, f, lf;
  fault_rec_pkg::handler_entry_t fault_entry, parallel_entry;
  fault_rec_pkg::call_t call;
  logic [31:0] seed = 32'h0000_001C;
  logic [31:0] mem [logic [31:0]];
  logic [15:0] kinds [6] = '{16'h0101, 16'h0201, 16'h0302, 16'h0301, 16'h0501, 16'h0702};
  int failures = 0;
  int check_count = 0;

  parallel_fault_recorder dut (.clk_sys, .rst, .fault_req, .fault_info, .late_ovf_valid,
    .late_ovf_info, .no_imprecise_flag, .pc_trace_enable, .pc_word, .ac_word, .stack_ptr,
    .prev_fp, .next_ip, .fault_entry, .parallel_entry, .mem_wr_ready, .handler_ret, .busy,
    .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .rf_wr_en, .rf_wr_idx, .rf_wr_data,
    .call_valid, .call, .trace_enable_bit, .resume_valid, .resume_pointer, .resume_defined,
    .resumable);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'h8020_0003 : seed >> 1;
    return seed;
  endfunction : rnd

  function automatic fault_rec_pkg::fault_info_t mk(input logic [15:0] k);
    fault_rec_pkg::fault_info_t r;
    r = {k, rnd(), rnd(), rnd(), 1'b1, rnd(), 5'(rnd())};
    return r;
  endfunction : mk

  function automatic logic [31:0] tw(input fault_rec_pkg::fault_info_t x);
    return {8'h00, x.ftype, 8'h00, x.fsub};
  endfunction : tw

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // Memory sink with random stalls
  always @(posedge clk_sys) begin
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) mem[mem_wr_addr] = mem_wr_data;
    mem_wr_ready <= 1'(rnd() >> 5);
  end

  // ------------------------------------------------------------
  // Fault sequences
  // ------------------------------------------------------------
  task automatic req(input logic late_on);
    @(posedge clk_sys);
    stack_ptr <= rnd();
    prev_fp <= rnd();
    pc_word <= rnd();
    ac_word <= rnd();
    next_ip <= rnd();
    fault_entry <= 33'(rnd());
    parallel_entry <= {rnd(), 1'b0};
    pc_trace_enable <= 1'(rnd());
    @(posedge clk_sys);
    fault_info <= f;
    fault_req <= 1'b1;
    @(posedge clk_sys);
    fault_req <= 1'b0;
    late_ovf_info <= lf;
    late_ovf_valid <= late_on;
    @(posedge clk_sys);
    late_ovf_valid <= 1'b0;
  endtask : req

  task automatic fin(input fault_rec_pkg::fault_info_t p, input logic par);
    logic [31:0] fr, rp;
    int n;
    n = 0;
    while (call_valid !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 4000) failures++;
    fr = ((stack_ptr + 32'h0000_000F) & 32'hFFFF_FFF0) + 32'h0000_0050;
    rp = par ? next_ip : (p.ftype == fault_rec_pkg::FT_OPERATION ? p.ip : p.rsm);
    chk(call.frame, fr, "frame pointer");
    chk(call.parallel, par, "record kind");
    chk(call.ip, (par ? parallel_entry.ip : fault_entry.ip) & 32'hFFFF_FFFC, "entry");
    chk(call.sup_mode, par | fault_entry.sup_mode, "mode");
    chk(trace_enable_bit, !par & pc_trace_enable, "trace at entry");
    chk(resumable, !par && (p.ftype != 8'h03 || p.fsub != 8'h01), "resumable");
    chk(busy, 1'b1, "busy in handler");
    chk(mem[fr - 20], {8'h00, par ? 8'h00 : 8'hFF, 8'h00, par ? 8'h02 : 8'h01}, "ovr");
    chk(mem[fr - 8], tw(p), "type word");
    chk(mem[fr - 4], p.ip, "fault ip");
    chk(mem[fr - 24], p.data, "fault data");
    chk(mem[fr - 16], pc_word, "saved pc");
    chk(mem[fr - 12], ac_word, "saved ac");
    chk(mem[fr - 28], 32'h0, "spare word");
    chk(mem[prev_fp + 8], rp, "saved resume");
    if (par) begin
      chk(mem[fr - 72], tw(lf), "second type");
      chk(mem[fr - 68], lf.ip, "second ip");
      chk(mem[fr - 96], lf.data, "second data");
    end
    @(posedge clk_sys);
    handler_ret <= 1'b1;
    @(posedge clk_sys);
    handler_ret <= 1'b0;
    n = 0;
    while (resume_valid !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 100) failures++;
    chk(resume_pointer, rp, "resume pointer");
    chk(resume_defined, par ? p.rsm_def & lf.rsm_def : p.rsm_def, "defined");
    chk(trace_enable_bit, pc_trace_enable, "trace restored");
    mem.delete();
  endtask : fin

  initial begin
    rst = 1'b1;
    {fault_req, late_ovf_valid, no_imprecise_flag, pc_trace_enable, handler_ret} = '0;
    {fault_info, late_ovf_info, fault_entry, parallel_entry} = '0;
    {pc_word, ac_word, stack_ptr, prev_fp, next_ip} = '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      f = mk(kinds[i]);
      req(1'b0);
      fin(f, 1'b0);
    end
    // Combined record with an undefined late resume pointer, then one with a defined one
    for (int k = 0; k < 2; k++) begin
      f = mk(16'h0301);
      lf = mk(16'h0301);
      lf.rsm_def = k[0];
      req(1'b1);
      fin(f, 1'b1);
    end
    // Combining forbidden: late fault is reported alone afterwards
    @(posedge clk_sys);
    no_imprecise_flag <= 1'b1;
    f = mk(16'h0501);
    lf = mk(16'h0301);
    req(1'b1);
    fin(f, 1'b0);
    fin(lf, 1'b0);
    test_done();
  end

  // Whole run needs a few thousand cycles; 50000 leaves ample margin
  initial begin
    #400000;
    failures++;
    test_done();
  end
endmodule : parallel_fault_recorder_tb
